// *** rtl/tcc_edge_sync.sv ***
/*
 * Two-flop synchroniser with optional four-sample filter and edge detect.
 * Assumes the input is asynchronous to i_clk_sys.
 */
`timescale 1ns/1ps
module tcc_edge_sync
    import tcc_pkg::*;
(
    // Clock and reset
    input  wire logic i_clk_sys,
    input  wire logic i_rst_n,
    // Control
    input  wire logic i_filter_en,
    // Signal
    input  wire logic i_async,
    output logic      o_level,
    output logic      o_rise,
    output logic      o_fall
);

    typedef struct packed {
        logic                    meta;
        logic                    sync;
        logic [TCC_FILT_LEN-2:0] hist;
        logic                    filt;
        logic                    prev;
    } tcc_es_t;

    tcc_es_t st_reg;
    tcc_es_t st_next;
    logic    src;

    always_comb begin
        st_next      = st_reg;
        st_next.meta = i_async;
        st_next.sync = st_reg.meta;
        st_next.hist = {st_reg.hist[TCC_FILT_LEN-3:0], st_reg.sync};
        // RULE14 four equal samples
        // Newest sample counts too, so the filter adds exactly four cycles
        if (&{st_reg.hist, st_reg.sync}) begin
            st_next.filt = 1'b1;
        end else if (~|{st_reg.hist, st_reg.sync}) begin
            st_next.filt = 1'b0;
        end
        // RULE13 filter adds delay
        src          = i_filter_en ? st_reg.filt : st_reg.sync;
        st_next.prev = src;
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_level = st_reg.prev;
    // RULE4 one pulse per edge
    assign o_rise  = src & ~st_reg.prev;
    assign o_fall  = ~src & st_reg.prev;

endmodule

// *** rtl/tcc_pkg.sv ***
/*
 * Constants shared by the timer/capture/compare core.
 * Assumes a single system clock; registers are reached through plain ports.
 */
//----------------------------------------------------------------
// Operation
//----------------------------------------------------------------
// Operation
// RULE1 - External pin updates counter 2.5-3.5 cycles later; the code takes 2-3 cycles (two sync flops, combinational edge detect)
// RULE2 - Enable external count only while pin stable
// RULE3 - External clock below system clock over two
// RULE4 - Each external edge gives one tick
// RULE5 - Count up to top, then restart zero
// RULE6 - Clock select zero stops; CPU access remains
// RULE7 - CPU count write beats clear or increment
// RULE8 - Overflow flag set at maximum, requests interrupt
// RULE9 - Capture source pin, or comparator when selected
// RULE10 - Matching edge copies count, sets capture flag
// RULE11 - Capture flag cleared by service or write-one
// RULE12 - Source switch may capture; software clears flag
// RULE13 - Capture inputs synchronised; filter adds four cycles
// RULE14 - Filter needs four equal samples, system clock
// RULE15 - Capture uses compare A low, B high
// RULE16 - New capture overwrites unread capture value
// RULE17 - Equality sets compare flag next tick
// RULE18 - 8-bit: flags A,B; 16-bit: A only
// RULE19 - Compare flags cleared by service or write-one
// RULE20 - Count write blocks matches next tick
// RULE21 - Duty measurement: flip edge, clear flag
// RULE22 - Driven port bit of capture pin captures
// RULE23 - Clear-on-match resets counter at compare A
// RULE24 - Select 7 rising ticks, 6 falling ticks
// RULE25 - 16-bit normal wraps at ffff, sets overflow
package tcc_pkg;

    localparam logic [2:0]  TCC_CS_STOP    = 3'h0;
    localparam logic [2:0]  TCC_CS_SYS     = 3'h1;
    localparam logic [2:0]  TCC_CS_EXT_FALL = 3'h6;
    localparam logic [2:0]  TCC_CS_EXT_RISE = 3'h7;
    localparam logic [15:0] TCC_MAX16      = 16'hffff;
    localparam logic [7:0]  TCC_MAX8       = 8'hff;
    localparam logic [15:0] TCC_COUNT_RST  = 16'h0000;
    localparam logic [7:0]  TCC_REG_RST    = 8'h00;
    localparam int          TCC_FILT_LEN   = 4;

endpackage

// *** rtl/tcc_timer.sv ***
/*
 * Timer/counter core: tick selection, 8/16-bit counter, input capture
 * and two-channel compare. Assumes the CPU side presents one-cycle write
 * strobes with full 16-bit data (byte pairing is done outside), and
 * one-cycle interrupt-service pulses per flag.
 */
`timescale 1ns/1ps
module tcc_timer
    import tcc_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_reset_n,
    // Control configuration
    input  wire logic [2:0]  i_clock_select,
    input  wire logic        i_prescale_tick,
    input  wire logic        i_width_sel,
    input  wire logic        i_clear_on_match_sel,
    input  wire logic        i_capture_mode_en,
    input  wire logic        i_comparator_capture_sel,
    input  wire logic        i_capture_filter_en,
    input  wire logic        i_capture_rising,
    input  wire logic        i_capture_irq_en,
    input  wire logic        i_compare_a_irq_en,
    input  wire logic        i_compare_b_irq_en,
    input  wire logic        i_overflow_irq_en,
    // CPU writes
    input  wire logic        i_count_wr,
    input  wire logic [15:0] i_count_wdata,
    input  wire logic        i_compare_a_wr,
    input  wire logic [7:0]  i_compare_a_wdata,
    input  wire logic        i_compare_b_wr,
    input  wire logic [7:0]  i_compare_b_wdata,
    // Flag clears (write-one or interrupt service)
    input  wire logic        i_overflow_clr,
    input  wire logic        i_capture_clr,
    input  wire logic        i_compare_a_clr,
    input  wire logic        i_compare_b_clr,
    // Pins
    input  wire logic        i_ext_count_pin,
    input  wire logic        i_capture_pin,
    input  wire logic        i_comparator_out,
    // Status
    output logic [15:0]      o_count_value,
    output logic [7:0]       o_compare_a_reg,
    output logic [7:0]       o_compare_b_reg,
    output logic             o_overflow_flag,
    output logic             o_capture_flag,
    output logic             o_compare_a_flag,
    output logic             o_compare_b_flag,
    output logic             o_overflow_irq,
    output logic             o_capture_irq,
    output logic             o_compare_a_irq,
    output logic             o_compare_b_irq
);

    //----------------------------------------------------------------
    // Reset release
    //----------------------------------------------------------------
    logic [1:0] rst_sync_reg;
    logic       rst_n;

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    //----------------------------------------------------------------
    // Input synchronisers
    //----------------------------------------------------------------
    logic ext_rise;
    logic ext_fall;
    logic cap_pin_rise;
    logic cap_pin_fall;
    logic cap_pin_lvl;
    logic cmp_rise;
    logic cmp_fall;
    logic cmp_lvl;

    // RULE1 sync then edge
    tcc_edge_sync u_ext_sync (
        .i_clk_sys   (i_clk_sys),
        .i_rst_n     (rst_n),
        .i_filter_en (1'b0),
        .i_async     (i_ext_count_pin),
        .o_level     (),
        .o_rise      (ext_rise),
        .o_fall      (ext_fall)
    );

    // RULE13 same sync path
    // RULE22 port-driven pin captures too
    tcc_edge_sync u_cap_sync (
        .i_clk_sys   (i_clk_sys),
        .i_rst_n     (rst_n),
        .i_filter_en (i_capture_filter_en),
        .i_async     (i_capture_pin),
        .o_level     (cap_pin_lvl),
        .o_rise      (cap_pin_rise),
        .o_fall      (cap_pin_fall)
    );

    tcc_edge_sync u_cmp_sync (
        .i_clk_sys   (i_clk_sys),
        .i_rst_n     (rst_n),
        .i_filter_en (i_capture_filter_en),
        .i_async     (i_comparator_out),
        .o_level     (cmp_lvl),
        .o_rise      (cmp_rise),
        .o_fall      (cmp_fall)
    );

    //----------------------------------------------------------------
    // State
    //----------------------------------------------------------------
    typedef struct packed {
        logic [15:0] count;
        logic [7:0]  cmp_a;
        logic [7:0]  cmp_b;
        logic        ovf_flag;
        logic        cap_flag;
        logic        cmpa_flag;
        logic        cmpb_flag;
        logic        block;
        logic        src_sel;
        logic        src_lvl;
        logic        ovf_irq;
        logic        cap_irq;
        logic        cmpa_irq;
        logic        cmpb_irq;
    } tcc_state_t;

    tcc_state_t st_reg;
    tcc_state_t st_next;

    logic        tick;
    logic        cap_edge;
    logic        sel_lvl;
    logic        cap_event;
    logic [15:0] top;
    logic [15:0] max_val;
    logic        at_top;
    logic        eq_a;
    logic        eq_b;
    logic        cmp_active;
    logic        match_a;
    logic        match_b;

    always_comb begin
        st_next = st_reg;

        //----------------------------------------------------------------
        // Tick selection
        //----------------------------------------------------------------
        // RULE6 stopped at zero
        // RULE24 edge by select
        case (i_clock_select)
            TCC_CS_STOP:     tick = 1'b0;
            TCC_CS_SYS:      tick = 1'b1;
            TCC_CS_EXT_FALL: tick = ext_fall;
            TCC_CS_EXT_RISE: tick = ext_rise;
            default:         tick = i_prescale_tick;
        endcase

        //----------------------------------------------------------------
        // Capture source
        //----------------------------------------------------------------
        // RULE9 capture source select
        sel_lvl  = i_comparator_capture_sel ? cmp_lvl : cap_pin_lvl;
        cap_edge = i_comparator_capture_sel
                 ? (i_capture_rising ? cmp_rise : cmp_fall)
                 : (i_capture_rising ? cap_pin_rise : cap_pin_fall);
        // RULE12 source switch may capture
        cap_event = i_capture_mode_en &
                    (cap_edge |
                     ((st_reg.src_sel != i_comparator_capture_sel) &
                      (st_reg.src_lvl != sel_lvl) &
                      (sel_lvl == i_capture_rising)));
        st_next.src_sel = i_comparator_capture_sel;
        st_next.src_lvl = sel_lvl;

        //----------------------------------------------------------------
        // Counter
        //----------------------------------------------------------------
        max_val = i_width_sel ? TCC_MAX16 : {8'h00, TCC_MAX8};
        // RULE23 clear at compare A
        top = (!i_width_sel && !i_capture_mode_en && i_clear_on_match_sel)
            ? {8'h00, st_reg.cmp_a} : max_val;
        at_top = (st_reg.count == top);

        // RULE7 CPU write wins
        // RULE5 increment and wrap
        if (i_count_wr) begin
            st_next.count = i_width_sel ? i_count_wdata : {8'h00, i_count_wdata[7:0]};
        end else if (tick) begin
            st_next.count = at_top ? TCC_COUNT_RST : st_reg.count + 16'h0001;
        end

        // RULE8 overflow at maximum
        // RULE25 wrap ffff sets overflow
        if (tick && !i_count_wr && st_reg.count == max_val) begin
            st_next.ovf_flag = 1'b1;
        end else if (i_overflow_clr) begin
            st_next.ovf_flag = 1'b0;
        end

        // RULE15 capture shares compare regs
        // RULE16 overwrite on each capture
        if (i_compare_a_wr) begin
            st_next.cmp_a = i_compare_a_wdata;
        end
        if (i_compare_b_wr) begin
            st_next.cmp_b = i_compare_b_wdata;
        end
        // RULE10 copy and flag together
        if (cap_event) begin
            st_next.cmp_a = st_reg.count[7:0];
            if (i_width_sel) begin
                st_next.cmp_b = st_reg.count[15:8];
            end
        end

        // RULE11 set beats clear
        if (cap_event) begin
            st_next.cap_flag = 1'b1;
        end else if (i_capture_clr) begin
            st_next.cap_flag = 1'b0;
        end

        //----------------------------------------------------------------
        // Compare
        //----------------------------------------------------------------
        // RULE17 continuous compare
        // RULE18 unit count per width
        // Equality is taken on the tick that moves the count on, so a
        // written count equal to a compare value meets the block
        eq_a = i_width_sel ? (st_reg.count == {st_reg.cmp_b, st_reg.cmp_a})
                           : (st_reg.count[7:0] == st_reg.cmp_a);
        eq_b = (st_reg.count[7:0] == st_reg.cmp_b);
        cmp_active = !(i_capture_mode_en && i_width_sel);
        match_a = eq_a && cmp_active && !i_capture_mode_en;
        match_b = eq_b && !i_width_sel;

        // RULE20 write blocks next tick
        if (i_count_wr) begin
            st_next.block = 1'b1;
        end else if (tick) begin
            st_next.block = 1'b0;
        end

        // RULE19 set beats clear
        if (tick && match_a && !st_reg.block && !i_count_wr) begin
            st_next.cmpa_flag = 1'b1;
        end else if (i_compare_a_clr) begin
            st_next.cmpa_flag = 1'b0;
        end
        if (tick && match_b && !st_reg.block && !i_count_wr) begin
            st_next.cmpb_flag = 1'b1;
        end else if (i_compare_b_clr) begin
            st_next.cmpb_flag = 1'b0;
        end

        //----------------------------------------------------------------
        // Interrupt requests
        //----------------------------------------------------------------
        st_next.ovf_irq  = st_next.ovf_flag & i_overflow_irq_en;
        st_next.cap_irq  = st_next.cap_flag & i_capture_irq_en;
        st_next.cmpa_irq = st_next.cmpa_flag & i_compare_a_irq_en;
        st_next.cmpb_irq = st_next.cmpb_flag & i_compare_b_irq_en;
    end

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    //----------------------------------------------------------------
    // Outputs
    //----------------------------------------------------------------
    assign o_count_value    = st_reg.count;
    assign o_compare_a_reg  = st_reg.cmp_a;
    assign o_compare_b_reg  = st_reg.cmp_b;
    assign o_overflow_flag  = st_reg.ovf_flag;
    assign o_capture_flag   = st_reg.cap_flag;
    assign o_compare_a_flag = st_reg.cmpa_flag;
    assign o_compare_b_flag = st_reg.cmpb_flag;
    assign o_overflow_irq   = st_reg.ovf_irq;
    assign o_capture_irq    = st_reg.cap_irq;
    assign o_compare_a_irq  = st_reg.cmpa_irq;
    assign o_compare_b_irq  = st_reg.cmpb_irq;

endmodule

// *** tb/tb_top.sv ***
/*
 * Self-checking bench for the timer core: counting, capture, compare.
 * Assumes the pin model drives the three pins; inputs change at negedge.
 */
`timescale 1ns/1ps
module tb_top;
    import tcc_pkg::*;
    logic i_clk_sys = 1'b0, i_reset_n = 1'b0, i_prescale_tick = 1'b0;
    logic [2:0] i_clock_select = TCC_CS_STOP;
    logic i_width_sel = 1'b1, i_clear_on_match_sel = 1'b0, i_capture_mode_en = 1'b0;
    logic i_comparator_capture_sel = 1'b0, i_capture_filter_en = 1'b0, i_capture_rising = 1'b1;
    logic i_capture_irq_en = 1'b1, i_compare_a_irq_en = 1'b1;
    logic i_compare_b_irq_en = 1'b1, i_overflow_irq_en = 1'b1;
    logic i_count_wr = 1'b0, i_compare_a_wr = 1'b0, i_compare_b_wr = 1'b0;
    logic [15:0] i_count_wdata = 16'h0000;
    logic [7:0] i_compare_a_wdata = 8'h00, i_compare_b_wdata = 8'h00;
    logic i_overflow_clr = 1'b0, i_capture_clr = 1'b0, i_compare_a_clr = 1'b0;
    logic i_compare_b_clr = 1'b0;
    wire logic i_ext_count_pin, i_capture_pin, i_comparator_out;
    logic [15:0] o_count_value, mx;
    logic [7:0] o_compare_a_reg, o_compare_b_reg;
    logic o_overflow_flag, o_capture_flag, o_compare_a_flag, o_compare_b_flag;
    logic o_overflow_irq, o_capture_irq, o_compare_a_irq, o_compare_b_irq;
    int failures = 0, checks = 0;
    tcc_timer dut (.i_clk_sys, .i_reset_n, .i_clock_select, .i_prescale_tick, .i_width_sel,
        .i_clear_on_match_sel, .i_capture_mode_en, .i_comparator_capture_sel,
        .i_capture_filter_en, .i_capture_rising, .i_capture_irq_en, .i_compare_a_irq_en,
        .i_compare_b_irq_en, .i_overflow_irq_en, .i_count_wr, .i_count_wdata, .i_compare_a_wr,
        .i_compare_a_wdata, .i_compare_b_wr, .i_compare_b_wdata, .i_overflow_clr,
        .i_capture_clr, .i_compare_a_clr, .i_compare_b_clr, .i_ext_count_pin, .i_capture_pin,
        .i_comparator_out, .o_count_value, .o_compare_a_reg, .o_compare_b_reg,
        .o_overflow_flag, .o_capture_flag, .o_compare_a_flag, .o_compare_b_flag,
        .o_overflow_irq, .o_capture_irq, .o_compare_a_irq, .o_compare_b_irq);
    tcc_pin_model pm (.i_clk_sys(i_clk_sys), .o_ext_count_pin(i_ext_count_pin),
        .o_capture_pin(i_capture_pin), .o_comparator_out(i_comparator_out));
    initial forever #5 i_clk_sys = ~i_clk_sys;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge i_clk_sys);
    endtask
    task automatic wr_count(input logic [15:0] v);
        @(negedge i_clk_sys);
        i_count_wdata = v;
        i_count_wr = 1'b1;
        @(negedge i_clk_sys);
        i_count_wr = 1'b0;
    endtask
    task automatic wr_cmp(input logic [7:0] a, input logic [7:0] b);
        @(negedge i_clk_sys);
        {i_compare_a_wdata, i_compare_b_wdata, i_compare_a_wr, i_compare_b_wr} = {a, b, 2'h3};
        @(negedge i_clk_sys);
        {i_compare_a_wr, i_compare_b_wr} = 2'h0;
    endtask
    // Mask order: overflow, capture, compare a, compare b
    task automatic clr(input logic [3:0] m);
        @(negedge i_clk_sys);
        {i_overflow_clr, i_capture_clr, i_compare_a_clr, i_compare_b_clr} = m;
        @(negedge i_clk_sys);
        {i_overflow_clr, i_capture_clr, i_compare_a_clr, i_compare_b_clr} = 4'h0;
    endtask
    task automatic conclude;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        #100us;
        failures++;
        conclude();
    end
    initial begin
        tick(12);
        i_reset_n = 1'b1;
        tick(3);
        wr_count(16'h1234);
        tick(5);
        chk(o_count_value, 16'h1234);
        i_width_sel = 1'b0;
        i_clock_select = TCC_CS_SYS;
        wr_count(16'h01fe);
        chk(o_count_value, 16'h00fe);
        tick(1);
        chk(o_count_value, 16'h00ff);
        tick(1);
        chk({o_count_value[0], o_overflow_flag, o_overflow_irq}, 16'h3);
        clr(4'h8);
        chk(o_overflow_flag, 16'h0);
        i_width_sel = 1'b1;
        wr_count(16'hfffe);
        tick(2);
        chk(o_count_value, 16'h0);
        chk(o_overflow_flag, 16'h1);
        i_width_sel = 1'b0;
        clr(4'hf);
        wr_cmp(8'h20, 8'h30);
        wr_count(16'h0010);
        tick(40);
        chk({o_compare_a_flag, o_compare_b_flag, o_compare_a_irq}, 16'h7);
        i_width_sel = 1'b1;
        clr(4'hf);
        wr_cmp(8'h40, 8'h00);
        wr_count(16'hfff0);
        tick(100);
        chk({o_compare_a_flag, o_compare_b_flag}, 16'h2);
        i_width_sel = 1'b0;
        i_clear_on_match_sel = 1'b1;
        wr_cmp(8'h05, 8'h00);
        wr_count(16'h0000);
        clr(4'hf);
        mx = 16'h0000;
        repeat (20) begin
            tick(1);
            if (o_count_value > mx) mx = o_count_value;
        end
        chk(mx, 16'h5);
        chk(o_compare_a_flag, 16'h1);
        i_clear_on_match_sel = 1'b0;
        i_clock_select = TCC_CS_STOP;
        wr_cmp(8'h60, 8'h00);
        wr_count(16'h0060);
        clr(4'hf);
        i_clock_select = TCC_CS_SYS;
        tick(3);
        chk(o_compare_a_flag, 16'h0);
        i_clock_select = TCC_CS_STOP;
        wr_count(16'h0000);
        i_clock_select = TCC_CS_EXT_RISE;
        pm.ext_toggle(1);
        tick(2);
        chk(o_count_value, 16'h0);
        tick(1);
        chk(o_count_value, 16'h1);
        pm.ext_toggle(7);
        tick(4);
        chk(o_count_value, 16'h4);
        i_clock_select = TCC_CS_EXT_FALL;
        pm.ext_toggle(4);
        tick(4);
        chk(o_count_value, 16'h6);
        i_clock_select = TCC_CS_STOP;
        {i_capture_mode_en, i_width_sel} = 2'h3;
        wr_count(16'h4321);
        clr(4'hf);
        pm.set_cap(1'b1, 1'b0);
        tick(2);
        chk(o_capture_flag, 16'h0);
        tick(1);
        chk({o_compare_b_reg, o_compare_a_reg}, 16'h4321);
        chk({o_capture_flag, o_capture_irq}, 16'h3);
        wr_count(16'h5555);
        pm.set_cap(1'b0, 1'b0);
        pm.set_cap(1'b1, 1'b0);
        tick(4);
        chk({o_compare_b_reg, o_compare_a_reg}, 16'h5555);
        clr(4'h4);
        chk(o_capture_flag, 16'h0);
        i_comparator_capture_sel = 1'b1;
        tick(5);
        clr(4'h4);
        wr_count(16'h0777);
        pm.set_cap(1'b1, 1'b1);
        tick(4);
        wr_count(16'h0888);
        pm.set_cap(1'b0, 1'b1);
        pm.set_cap(1'b1, 1'b1);
        tick(4);
        chk({o_compare_b_reg, o_compare_a_reg}, 16'h0777);
        {i_comparator_capture_sel, i_capture_filter_en} = 2'h1;
        tick(12);
        wr_count(16'h0999);
        clr(4'h4);
        pm.set_cap(1'b0, 1'b1);
        pm.set_cap(1'b1, 1'b1);
        tick(12);
        chk(o_capture_flag, 16'h0);
        i_capture_rising = 1'b0;
        clr(4'h4);
        pm.set_cap(1'b0, 1'b1);
        tick(6);
        chk(o_capture_flag, 16'h0);
        tick(1);
        chk(o_capture_flag, 16'h1);
        conclude();
    end
endmodule

// *** tb/tcc_pin_model.sv ***
/*
 * Far-side pins: external count source, capture pin and comparator.
 * Assumes the bench calls its tasks; pins change at falling edges only.
 */
`timescale 1ns/1ps
module tcc_pin_model (
    input  wire logic i_clk_sys,
    output logic      o_ext_count_pin,
    output logic      o_capture_pin,
    output logic      o_comparator_out
);
    initial begin
        o_ext_count_pin = 1'b0;
        o_capture_pin = 1'b0;
        o_comparator_out = 1'b0;
    end
    task automatic ext_toggle(input int n);
        repeat (n) begin
            repeat (4) @(negedge i_clk_sys);
            o_ext_count_pin = ~o_ext_count_pin;
        end
    endtask
    task automatic set_cap(input logic p, input logic c);
        @(negedge i_clk_sys);
        o_capture_pin = p;
        o_comparator_out = c;
    endtask
endmodule

// *** tb/tcc_timer_props.sv ***
/*
 * Concurrent checks on the timer core ports.
 * Assumes one system clock and the two-flop reset release of the core.
 */
`timescale 1ns/1ps
module tcc_timer_props
    import tcc_pkg::*;
(
    input wire logic        i_clk_sys,
    input wire logic        i_reset_n,
    input wire logic [2:0]  i_clock_select,
    input wire logic        i_width_sel,
    input wire logic        i_clear_on_match_sel,
    input wire logic        i_capture_mode_en,
    input wire logic        i_count_wr,
    input wire logic [15:0] i_count_wdata,
    input wire logic        i_capture_clr,
    input wire logic [15:0] o_count_value,
    input wire logic [7:0]  o_compare_a_reg,
    input wire logic        o_overflow_flag,
    input wire logic        o_capture_flag,
    input wire logic        o_compare_a_flag,
    input wire logic        o_compare_b_flag,
    input wire logic        o_capture_irq,
    input wire logic        o_compare_a_irq
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    // Core lags external reset by two flops, so wait it out
    logic [1:0] up_reg;
    logic       rdy;
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) up_reg <= 2'h0;
        else if (up_reg != 2'h3) up_reg <= up_reg + 2'h1;
    end
    assign rdy = (up_reg == 2'h3) && !i_count_wr;
    wire run = (i_clock_select == TCC_CS_SYS);
    property p_wr;
        up_reg == 2'h3 && i_count_wr |=> o_count_value ==
            ($past(i_width_sel) ? $past(i_count_wdata) : ($past(i_count_wdata) & 16'h00ff));
    endproperty
    a_wr: assert property (p_wr) else $error("count write lost");
    property p_stop;
        rdy && i_clock_select == TCC_CS_STOP && $past(i_clock_select) == TCC_CS_STOP
            |=> $stable(o_count_value);
    endproperty
    a_stop: assert property (p_stop) else $error("stopped counter moved");
    property p_inc;
        rdy && run && $past(run) && !i_width_sel && !i_clear_on_match_sel
            && o_count_value < 16'h00ff |=> o_count_value == $past(o_count_value) + 16'h0001;
    endproperty
    a_inc: assert property (p_inc) else $error("counter did not step");
    property p_ov8;
        rdy && run && !i_width_sel && o_count_value == 16'h00ff |=> o_overflow_flag;
    endproperty
    a_ov8: assert property (p_ov8) else $error("8-bit overflow missed");
    property p_ov16;
        rdy && run && i_width_sel && o_count_value == TCC_MAX16
            |=> o_count_value == 16'h0000 && o_overflow_flag;
    endproperty
    a_ov16: assert property (p_ov16) else $error("16-bit wrap wrong");
    property p_ctc;
        rdy && run && $past(run) && !i_width_sel && !i_capture_mode_en && i_clear_on_match_sel
            && o_count_value == {8'h00, o_compare_a_reg} |=> o_count_value == 16'h0000;
    endproperty
    a_ctc: assert property (p_ctc) else $error("clear on match missed");
    property p_capkeep;
        o_capture_flag && !i_capture_clr |=> o_capture_flag;
    endproperty
    a_capkeep: assert property (p_capkeep) else $error("capture flag dropped");
    property p_capirq;
        o_capture_irq |-> o_capture_flag;
    endproperty
    a_capirq: assert property (p_capirq) else $error("capture irq without flag");
    property p_b16;
        $rose(o_compare_b_flag) |-> !$past(i_width_sel);
    endproperty
    a_b16: assert property (p_b16) else $error("compare b set in 16-bit");
    property p_acap;
        $rose(o_compare_a_flag) |-> !$past(i_capture_mode_en);
    endproperty
    a_acap: assert property (p_acap) else $error("compare a set in capture");
    property p_airq;
        o_compare_a_irq |-> o_compare_a_flag;
    endproperty
    a_airq: assert property (p_airq) else $error("compare irq without flag");
endmodule

bind tcc_timer tcc_timer_props u_props (.i_clk_sys, .i_reset_n, .i_clock_select, .i_width_sel,
    .i_clear_on_match_sel, .i_capture_mode_en, .i_count_wr, .i_count_wdata, .i_capture_clr,
    .o_count_value, .o_compare_a_reg, .o_overflow_flag, .o_capture_flag, .o_compare_a_flag,
    .o_compare_b_flag, .o_capture_irq, .o_compare_a_irq);
